// File: gpio_expander_pkg.sv
// Constants, types and register map of the two-bank serial I/O expander.
// Assumes an I2C master on the far side and a 10 MHz local clock sampling the bus.
// Summary of operation
// - Command values zero to seven select input, output, invert, direction, banks 0 and 1.
// - Reading an input register returns each pin's present level, whatever its direction.
// - Writes to input registers are ignored; contents follow sampled pins only.
// - Input registers have no reset value; they follow the applied pin levels.
// - Output bit drives its pin only while the pin is an output.
// - Reading an output register returns the stored flip-flop value, not the pin.
// - Both output registers are read-write and reset to all ones.
// - Polarity inversion acts only on pins configured as inputs.
// - Polarity bit one inverts the reported level of its input pin.
// - Polarity bit zero reports the pin level unchanged.
// - Both polarity registers are read-write and reset to all zeros.
// - Direction bit one makes the pin an input, driver released.
// - Direction bit zero makes the pin an actively driven output.
// - Both direction registers are read-write and reset to all ones.
// - Last command byte is kept and serves every read until replaced.
// - Device answers at 7-bit address 0x20 plus the three select pins.
// - Last address bit one means read, zero means write.
package gpio_expander_pkg;

  // Bus address: high four bits fixed, low three from the select pins
  localparam logic [6:0] DEV_ADDR_BASE = 7'h20;

  // Register indices carried in the command byte
  localparam logic [2:0] REG_PIN_LEVEL_BANK0     = 3'h0;
  localparam logic [2:0] REG_PIN_LEVEL_BANK1     = 3'h1;
  localparam logic [2:0] REG_DRIVE_LEVEL_BANK0   = 3'h2;
  localparam logic [2:0] REG_DRIVE_LEVEL_BANK1   = 3'h3;
  localparam logic [2:0] REG_INVERT_SELECT_BANK0 = 3'h4;
  localparam logic [2:0] REG_INVERT_SELECT_BANK1 = 3'h5;
  localparam logic [2:0] REG_DIRECTION_BANK0     = 3'h6;
  localparam logic [2:0] REG_DIRECTION_BANK1     = 3'h7;

  // Register groups, command bits 2:1
  localparam logic [1:0] GRP_PIN_LEVEL = 2'h0;
  localparam logic [1:0] GRP_DRIVE     = 2'h1;
  localparam logic [1:0] GRP_INVERT    = 2'h2;
  localparam logic [1:0] GRP_DIRECTION = 2'h3;

  // Values after reset
  localparam logic [7:0] DRIVE_RESET     = 8'hff;
  localparam logic [7:0] INVERT_RESET    = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'hff;
  localparam logic [2:0] CMD_RESET       = 3'h0;
  localparam logic [1:0] BUS_IDLE_LEVELS = 2'h3;

  // Bit counting within one byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Local clock, for reference in the bench
  localparam int CLOCK_PERIOD_NS = 100;

  typedef logic [1:0][7:0] bank_pair_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } i2c_events_t;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_cmd,
    st_cmd_ack,
    st_wdata,
    st_wdata_ack,
    st_rdata,
    st_rdata_ack,
    st_ignore
  } slave_state_t;

endpackage

// File: pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes nothing of the source; output moves only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  if (WIDTH < 1) begin : g_check
    $error("pin_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] agree;

  // Stage one is only read by stage two
  assign agree     = ~(stage2_r ^ stage3_r);
  assign level_out = level_r;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_r <= RESET_VALUE;
      stage2_r <= RESET_VALUE;
      stage3_r <= RESET_VALUE;
      level_r  <= RESET_VALUE;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r  <= (agree & stage3_r) | (~agree & level_r);
    end
  end

endmodule

// File: i2c_line_events.sv
// Start, stop and clock-edge detection on already synchronised bus lines.
// Assumes both inputs come from the same synchroniser, so they share latency.
`timescale 1ns/1ps
module i2c_line_events (
  // Clock and reset
  input  wire logic                           clock_in,
  input  wire logic                           rst_n_in,
  // Filtered bus lines
  input  wire logic                           scl_in,
  input  wire logic                           sda_in,
  // Decoded events, one cycle each
  output gpio_expander_pkg::i2c_events_t      events_out
);

  logic scl_prev_r;
  logic sda_prev_r;

  // Data moving while the clock stays high marks start or stop
  assign events_out.start    = scl_in & scl_prev_r & sda_prev_r & ~sda_in;
  assign events_out.stop     = scl_in & scl_prev_r & ~sda_prev_r & sda_in;
  assign events_out.scl_rise = scl_in & ~scl_prev_r;
  assign events_out.scl_fall = ~scl_in & scl_prev_r;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_in;
      sda_prev_r <= sda_in;
    end
  end

endmodule

// File: i2c_gpio_expander_regs.sv
// Top of the two-bank I/O expander: bus slave, register file and pin drivers.
// Assumes open-drain bus wiring outside; pins and bus arrive unsynchronised.
`timescale 1ns/1ps
module i2c_gpio_expander_regs (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Serial bus, data line open drain
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // Address select straps
  input  wire logic [2:0]  addr_select_in,
  // Port pins, bank 1 in the upper byte
  input  wire logic [15:0] gpio_in,
  output logic      [15:0] gpio_out,
  output logic      [15:0] gpio_oe_out
);

  // Synchronised lines
  logic [1:0]                     bus_s;
  logic [2:0]                     addr_s;
  logic [15:0]                    gpio_s;
  gpio_expander_pkg::i2c_events_t ev;
  logic                           scl_s;
  logic                           sda_s;

  // Slave state
  gpio_expander_pkg::slave_state_t state_r;
  gpio_expander_pkg::slave_state_t state_nxt;
  logic [3:0]                      bit_cnt_r;
  logic [3:0]                      bit_cnt_nxt;
  logic [7:0]                      shift_r;
  logic [7:0]                      shift_nxt;
  logic                            read_dir_r;
  logic                            read_dir_nxt;
  logic [2:0]                      cmd_r;
  logic [2:0]                      cmd_nxt;
  logic                            sda_oe_r;
  logic                            sda_oe_nxt;
  logic                            sda_out_r;

  // Register file and pin drivers
  gpio_expander_pkg::bank_pair_t drive_r;
  gpio_expander_pkg::bank_pair_t invert_r;
  gpio_expander_pkg::bank_pair_t dir_r;
  gpio_expander_pkg::bank_pair_t level_banks;
  logic [15:0]                   gpio_out_r;
  logic [15:0]                   gpio_oe_r;

  // Decode wires
  logic       byte_done;
  logic       addr_hit;
  logic [6:0] own_addr;
  logic       wr_commit;
  logic       wr_drive;
  logic       wr_invert;
  logic       wr_dir;
  logic       wr_bank;
  logic [7:0] rd_byte;

  pin_sync #(
    .WIDTH       (2),
    .RESET_VALUE (gpio_expander_pkg::BUS_IDLE_LEVELS)
  ) u_bus_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .async_in  ({scl_in, sda_in}),
    .level_out (bus_s)
  );

  pin_sync #(
    .WIDTH       (3),
    .RESET_VALUE (3'h0)
  ) u_addr_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .async_in  (addr_select_in),
    .level_out (addr_s)
  );

  // Input levels carry no reset meaning; they follow the pins once synchronised
  pin_sync #(
    .WIDTH       (16),
    .RESET_VALUE (16'h0000)
  ) u_gpio_sync (
    .clock_in  (clock_in),
    .rst_n_in  (rst_n_in),
    .async_in  (gpio_in),
    .level_out (gpio_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];

  i2c_line_events u_events (
    .clock_in   (clock_in),
    .rst_n_in   (rst_n_in),
    .scl_in     (scl_s),
    .sda_in     (sda_s),
    .events_out (ev)
  );

  // Read value of the register that a command selects
  function automatic logic [7:0] reg_read(
    input logic [2:0]                    sel,
    input gpio_expander_pkg::bank_pair_t level,
    input gpio_expander_pkg::bank_pair_t drive,
    input gpio_expander_pkg::bank_pair_t invert,
    input gpio_expander_pkg::bank_pair_t dir
  );
    logic [7:0] value;
    value = 8'h00;
    unique case (sel[2:1])
      gpio_expander_pkg::GRP_PIN_LEVEL: begin
        // Inversion only on input pins, output pins report raw level
        value = level[sel[0]] ^ (invert[sel[0]] & dir[sel[0]]);
      end
      gpio_expander_pkg::GRP_DRIVE: begin
        value = drive[sel[0]];
      end
      gpio_expander_pkg::GRP_INVERT: begin
        value = invert[sel[0]];
      end
      gpio_expander_pkg::GRP_DIRECTION: begin
        value = dir[sel[0]];
      end
    endcase
    return value;
  endfunction

  assign level_banks = gpio_s;
  assign own_addr    = gpio_expander_pkg::DEV_ADDR_BASE | {4'h0, addr_s};
  assign addr_hit    = (shift_r[7:1] == own_addr);
  assign byte_done   = (bit_cnt_r == gpio_expander_pkg::BITS_PER_BYTE);
  assign rd_byte     = reg_read(cmd_r, level_banks, drive_r, invert_r, dir_r);

  // Writes land as the acknowledge is driven, never earlier
  assign wr_commit = (state_r == gpio_expander_pkg::st_wdata) & ev.scl_fall & byte_done;
  assign wr_bank   = cmd_r[0];
  assign wr_drive  = wr_commit & (cmd_r[2:1] == gpio_expander_pkg::GRP_DRIVE);
  assign wr_invert = wr_commit & (cmd_r[2:1] == gpio_expander_pkg::GRP_INVERT);
  assign wr_dir    = wr_commit & (cmd_r[2:1] == gpio_expander_pkg::GRP_DIRECTION);
  // Input group has no write strobe at all, the byte is acknowledged and dropped

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    read_dir_nxt = read_dir_r;
    cmd_nxt      = cmd_r;
    sda_oe_nxt   = sda_oe_r;
    if (ev.stop) begin
      state_nxt  = gpio_expander_pkg::st_idle;
      sda_oe_nxt = 1'b0;
    end else if (ev.start) begin
      // Repeated start restarts the address phase from any state
      state_nxt   = gpio_expander_pkg::st_addr;
      bit_cnt_nxt = 4'h0;
      sda_oe_nxt  = 1'b0;
    end else begin
      unique case (state_r)
        gpio_expander_pkg::st_idle,
        gpio_expander_pkg::st_ignore: begin
          sda_oe_nxt = 1'b0;
        end
        gpio_expander_pkg::st_addr,
        gpio_expander_pkg::st_cmd,
        gpio_expander_pkg::st_wdata: begin
          if (ev.scl_rise && !byte_done) begin
            shift_nxt   = {shift_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (ev.scl_fall && byte_done) begin
            bit_cnt_nxt = 4'h0;
            sda_oe_nxt  = 1'b1;
            if (state_r == gpio_expander_pkg::st_addr) begin
              if (addr_hit) begin
                read_dir_nxt = shift_r[0];
                state_nxt    = gpio_expander_pkg::st_addr_ack;
              end else begin
                sda_oe_nxt = 1'b0;
                state_nxt  = gpio_expander_pkg::st_ignore;
              end
            end else if (state_r == gpio_expander_pkg::st_cmd) begin
              // First byte after a write address is the command
              cmd_nxt   = shift_r[2:0];
              state_nxt = gpio_expander_pkg::st_cmd_ack;
            end else begin
              state_nxt = gpio_expander_pkg::st_wdata_ack;
            end
          end
        end
        gpio_expander_pkg::st_addr_ack: begin
          if (ev.scl_fall) begin
            if (read_dir_r) begin
              // Read starts from the kept command, no command byte here
              shift_nxt   = rd_byte;
              sda_oe_nxt  = ~rd_byte[7];
              bit_cnt_nxt = 4'h1;
              state_nxt   = gpio_expander_pkg::st_rdata;
            end else begin
              sda_oe_nxt  = 1'b0;
              bit_cnt_nxt = 4'h0;
              state_nxt   = gpio_expander_pkg::st_cmd;
            end
          end
        end
        gpio_expander_pkg::st_cmd_ack,
        gpio_expander_pkg::st_wdata_ack: begin
          if (ev.scl_fall) begin
            sda_oe_nxt  = 1'b0;
            bit_cnt_nxt = 4'h0;
            state_nxt   = gpio_expander_pkg::st_wdata;
          end
        end
        gpio_expander_pkg::st_rdata: begin
          if (ev.scl_fall) begin
            if (byte_done) begin
              sda_oe_nxt = 1'b0;
              state_nxt  = gpio_expander_pkg::st_rdata_ack;
            end else begin
              shift_nxt   = {shift_r[6:0], 1'b0};
              sda_oe_nxt  = ~shift_r[6];
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        gpio_expander_pkg::st_rdata_ack: begin
          if (ev.scl_rise && sda_s) begin
            // Master declined more data; wait for stop or start
            state_nxt = gpio_expander_pkg::st_ignore;
          end else if (ev.scl_fall) begin
            // Same register again, a fresh sample of the pins
            shift_nxt   = rd_byte;
            sda_oe_nxt  = ~rd_byte[7];
            bit_cnt_nxt = 4'h1;
            state_nxt   = gpio_expander_pkg::st_rdata;
          end
        end
        default: begin
          state_nxt = gpio_expander_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= gpio_expander_pkg::st_idle;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      read_dir_r <= 1'b0;
      cmd_r      <= gpio_expander_pkg::CMD_RESET;
      sda_oe_r   <= 1'b0;
      sda_out_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      read_dir_r <= read_dir_nxt;
      cmd_r      <= cmd_nxt;
      sda_oe_r   <= sda_oe_nxt;
      sda_out_r  <= 1'b0;
    end
  end

  // Register file, one byte per bank and group
  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        drive_r[b]  <= gpio_expander_pkg::DRIVE_RESET;
        invert_r[b] <= gpio_expander_pkg::INVERT_RESET;
        dir_r[b]    <= gpio_expander_pkg::DIRECTION_RESET;
      end else begin
        if (wr_drive && (wr_bank == 1'(b))) begin
          drive_r[b] <= shift_r;
        end
        if (wr_invert && (wr_bank == 1'(b))) begin
          invert_r[b] <= shift_r;
        end
        if (wr_dir && (wr_bank == 1'(b))) begin
          dir_r[b] <= shift_r;
        end
      end
    end
  end

  // Writes to the input group reach no storage

  // Pin drivers follow the registers one cycle later
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gpio_out_r <= 16'h0000;
      gpio_oe_r  <= 16'h0000;
    end else begin
      gpio_oe_r  <= ~dir_r;
      gpio_out_r <= drive_r & ~dir_r;
    end
  end

  assign sda_out     = sda_out_r;
  assign sda_oe_out  = sda_oe_r;
  assign gpio_out    = gpio_out_r;
  assign gpio_oe_out = gpio_oe_r;

endmodule

// File: gpio_expander_properties.sv
// Concurrent checks on the expander's pin and bus outputs.
// Assumes the bench binds it to the top module; bus clock low phases last 8 local cycles.
`timescale 1ns/1ps
module gpio_expander_properties (
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  // Bus
  input wire logic        scl_in,
  input wire logic        sda_oe_out,
  // Pins
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe_out
);
  logic [3:0] low_cnt_r;
  logic [3:0] low_cnt_nxt;

  // Cycles the bus clock has been low, saturating
  assign low_cnt_nxt = scl_in ? 4'h0 : ((low_cnt_r == 4'hf) ? low_cnt_r : low_cnt_r + 4'h1);

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_r <= 4'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_enables_quiet;
    $stable(gpio_oe_out)[*8];
  endsequence
  sequence s_levels_quiet;
    $stable(gpio_out)[*8];
  endsequence
  sequence s_all_inputs;
    (gpio_oe_out == 16'h0000 && gpio_out == 16'h0000 && !sda_oe_out)[*4];
  endsequence

  property p_drive_masked;
    (gpio_out & ~gpio_oe_out) == 16'h0000;
  endproperty
  a_drive_masked: assert property (p_drive_masked) else $error("level driven on a released pin");

  // Synchroniser delay puts every commit several cycles into the low phase
  property p_enable_timing;
    $changed(gpio_oe_out) |-> (!scl_in && low_cnt_r >= 4'h3 && low_cnt_r <= 4'h8);
  endproperty
  a_enable_timing: assert property (p_enable_timing) else $error("enables moved outside data acknowledge");

  property p_level_timing;
    $changed(gpio_out) |-> (!scl_in && low_cnt_r >= 4'h3 && low_cnt_r <= 4'h8);
  endproperty
  a_level_timing: assert property (p_level_timing) else $error("levels moved outside data acknowledge");

  property p_enable_hold;
    $changed(gpio_oe_out) |=> s_enables_quiet;
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enables changed twice within one byte");

  property p_level_hold;
    $changed(gpio_out) |=> s_levels_quiet;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("levels changed twice within one byte");

  property p_reset_inputs;
    $rose(rst_n_in) |-> ##1 s_all_inputs;
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pins not all inputs after reset");

  property p_sda_change_low;
    $changed(sda_oe_out) |-> (!scl_in && low_cnt_r >= 4'h3);
  endproperty
  a_sda_change_low: assert property (p_sda_change_low) else $error("data line moved while clock high");

  property p_sda_held;
    (sda_oe_out && $rose(scl_in)) |=> sda_oe_out[*3];
  endproperty
  a_sda_held: assert property (p_sda_held) else $error("data line released during clock high");
endmodule

// File: i2c_master_model.sv
// Bus master model: start, stop, byte send and receive.
// Assumes the bench resolves the pulled-up data wire and feeds it back.
`timescale 1ns/1ps
module i2c_master_model (
  // Bus wires
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  // Long low phase: the slave answers several local clocks after a fall
  localparam int LOW_NS  = 800;
  localparam int HIGH_NS = 600;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic start_c;
    #100 sda_low_out = 1'b0;
    #(LOW_NS - 100) scl_out = 1'b1;
    #(HIGH_NS) sda_low_out = 1'b1;
    #(HIGH_NS) scl_out = 1'b0;
  endtask

  task automatic stop_c;
    #100 sda_low_out = 1'b1;
    #(LOW_NS - 100) scl_out = 1'b1;
    #(HIGH_NS) sda_low_out = 1'b0;
    #(HIGH_NS);
  endtask

  // Data moves after the fall, never together with it
  task automatic bit_c(input logic b, output logic seen);
    #100 sda_low_out = ~b;
    #(LOW_NS - 100) scl_out = 1'b1;
    #(HIGH_NS / 2) seen = sda_in;
    #(HIGH_NS / 2) scl_out = 1'b0;
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(b[i], s);
    end
    bit_c(1'b1, ack);
  endtask

  task automatic rx(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, b[i]);
    end
    bit_c(nack, s);
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the two-bank expander, register model against the design.
// Assumes the master model in its own file; pins echo driven levels, else bench values.
`timescale 1ns/1ps
module tb;
  logic        clock_in;
  logic        rst_n_in;
  logic        scl_w;
  logic        sda_w;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe_out;
  logic [2:0]  addr_select;
  logic [15:0] ext_level;
  logic [15:0] gpio_in;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe_out;
  int          drv [2];
  int          inv [2];
  int          dir [2];
  int          mismatches;
  int          checks_done;
  int          cycles;
  int          seed;
  logic        ack;
  logic [7:0]  rbyte;

  // Open-drain data wire with pull-up
  assign sda_w = !sda_low && !(sda_oe_out && !sda_out);
  assign gpio_in = (gpio_out & gpio_oe_out) | (ext_level & ~gpio_oe_out);

  i2c_gpio_expander_regs dut (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n_in),
    .scl_in         (scl_w),
    .sda_in         (sda_w),
    .sda_out        (sda_out),
    .sda_oe_out     (sda_oe_out),
    .addr_select_in (addr_select),
    .gpio_in        (gpio_in),
    .gpio_out       (gpio_out),
    .gpio_oe_out    (gpio_oe_out)
  );

  i2c_master_model host (
    .scl_out     (scl_w),
    .sda_low_out (sda_low),
    .sda_in      (sda_w)
  );

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] expect_of(input int c);
    int b;
    int pin;
    b = c % 2;
    pin = ((drv[b] & ~dir[b]) | ((ext_level >> (8 * b)) & dir[b])) & 8'hff;
    case (c / 2)
      0: expect_of = 8'(pin ^ (inv[b] & dir[b]));
      1: expect_of = 8'(drv[b]);
      2: expect_of = 8'(inv[b]);
      default: expect_of = 8'(dir[b]);
    endcase
  endfunction

  task automatic wr(input int c, input logic [7:0] d);
    host.start_c();
    host.tx({gpio_expander_pkg::DEV_ADDR_BASE | {4'h0, addr_select}, 1'b0}, ack);
    chk("address ack", 16'(ack), 16'h0000);
    host.tx(8'(c), ack);
    chk("command ack", 16'(ack), 16'h0000);
    host.tx(d, ack);
    chk("data ack", 16'(ack), 16'h0000);
    chk("data drive level", 16'(sda_out), 16'h0000);
    host.stop_c();
    if (c >= 2) begin
      case (c / 2)
        1: drv[c % 2] = d;
        2: inv[c % 2] = d;
        default: dir[c % 2] = d;
      endcase
    end
    chk("pin enables", gpio_oe_out, ~{dir[1][7:0], dir[0][7:0]});
    chk("pin levels", gpio_out, {drv[1][7:0] & ~dir[1][7:0], drv[0][7:0] & ~dir[0][7:0]});
  endtask

  task automatic rd(input int c);
    logic [7:0] exp;
    host.start_c();
    host.tx({gpio_expander_pkg::DEV_ADDR_BASE | {4'h0, addr_select}, 1'b0}, ack);
    host.tx(8'(c), ack);
    // Odd registers are read through a repeated start instead of a stop
    if (c % 2 == 0) begin
      host.stop_c();
    end
    exp = expect_of(c);
    host.start_c();
    host.tx({gpio_expander_pkg::DEV_ADDR_BASE | {4'h0, addr_select}, 1'b1}, ack);
    chk("read address ack", 16'(ack), 16'h0000);
    for (int k = 0; k < 2; k++) begin
      host.rx(k == 1, rbyte);
      chk($sformatf("register %0d", c), 16'(rbyte), 16'(exp));
    end
    host.stop_c();
  endtask

  initial begin
    seed = 32'h4d5d;
    rst_n_in = 1'b0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    addr_select = 3'($random(seed));
    ext_level = 16'($random(seed));
    drv = '{255, 255};
    inv = '{0, 0};
    dir = '{255, 255};
    repeat (10) @(posedge clock_in);
    #5 rst_n_in = 1'b1;
    repeat (8) @(posedge clock_in);
    // Bus moves off the sampling edge from here on
    #5;
    chk("enables after reset", gpio_oe_out, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      rd(c);
    end
    host.start_c();
    host.tx({gpio_expander_pkg::DEV_ADDR_BASE | {4'h0, addr_select ^ 3'h1}, 1'b0}, ack);
    chk("foreign address ack", 16'(ack), 16'h0001);
    host.stop_c();
    for (int r = 0; r < 3; r++) begin
      for (int c = 0; c < 8; c++) begin
        wr(c, 8'($random(seed)));
      end
      @(posedge clock_in);
      #5 ext_level = 16'($random(seed));
      repeat (10) @(posedge clock_in);
      #5;
      for (int c = 0; c < 8; c++) begin
        rd(c);
      end
    end
    close_out();
  end
endmodule

bind i2c_gpio_expander_regs gpio_expander_properties props (
  .clock_in    (clock_in),
  .rst_n_in    (rst_n_in),
  .scl_in      (scl_in),
  .sda_oe_out  (sda_oe_out),
  .gpio_out    (gpio_out),
  .gpio_oe_out (gpio_oe_out)
);
